// file: hdl/fsm_pkg.sv
// Package of codes, widths and timing constants for the slave state monitor
package fsm_pkg;
  // Clock rate and derived one-second and one-millisecond counts
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SECOND_US = 1000000;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned SECOND_CYC = CLK_HZ / 1000000 * SECOND_US;
  localparam int unsigned MS_CYC = CLK_HZ / 1000000 * MS_US;

  // Generic link status codes
  localparam logic [2:0] LINK_INIT = 3'h1;
  localparam logic [2:0] LINK_OP = 3'h3;
  localparam logic [2:0] LINK_FAULTED = 3'h4;
  localparam logic [2:0] LINK_FAILING = 3'h5;
  localparam logic [2:0] LINK_PREOP = 3'h6;

  // Reported slave state codes
  localparam logic [2:0] RUN_INIT = 3'h1;
  localparam logic [2:0] RUN_PREOP = 3'h3;
  localparam logic [2:0] RUN_SAFEOP = 3'h4;
  localparam logic [2:0] RUN_OP = 3'h5;

  // Requested-state encoding on the command port
  localparam logic [3:0] REQ_INIT = 4'h1;
  localparam logic [3:0] REQ_PREOP = 4'h2;
  localparam logic [3:0] REQ_BOOT = 4'h3;
  localparam logic [3:0] REQ_SAFEOP = 4'h4;
  localparam logic [3:0] REQ_OP = 4'h8;

  // Application-layer status codes
  localparam logic [15:0] AL_OK = 16'h0000;
  localparam logic [15:0] AL_BAD_CHANGE = 16'h0011;
  localparam logic [15:0] AL_UNKNOWN = 16'h0012;
  localparam logic [15:0] AL_NO_BOOT = 16'h0013;
  localparam logic [15:0] AL_SM_CFG = 16'h0017;
  localparam logic [15:0] AL_SM_WDOG = 16'h001b;

  // Operating mode and description-file select codes
  localparam logic [1:0] MODE_NONE = 2'h1;
  localparam logic [1:0] MODE_BYPASS = 2'h3;
  localparam logic [1:0] DSEL_OFF = 2'h1;
  localparam logic [1:0] DSEL_STATIC = 2'h3;

  // Frame counter widths: good frames to 9999, bad frames one digit to 9
  localparam int unsigned GOOD_W = 14;
  localparam logic [13:0] GOOD_MAX = 14'h270f;
  localparam logic [3:0] BAD_MAX = 4'h9;

  // Slave state, Gray along Init, PreOp, SafeOp, Op
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_PREOP = 2'b01,
    ST_SAFEOP = 2'b11,
    ST_OP = 2'b10
  } fsm_state_t;
endpackage : fsm_pkg

// file: hdl/fsm_tick_if.sv
// Interface carrying the time-base enables from divider to monitor
`timescale 1ns/10ps
interface fsm_tick_if;
  logic ms_tick;
  logic sec_tick;
  modport src (output ms_tick, output sec_tick);
  modport dst (input ms_tick, input sec_tick);
endinterface : fsm_tick_if

// file: hdl/fsm_tick_gen.sv
// Divider producing one-cycle millisecond and second enables
`timescale 1ns/10ps
module fsm_tick_gen #(
  parameter int unsigned MS_CYCLES = fsm_pkg::MS_CYC,
  parameter int unsigned SEC_MS = 1000
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  fsm_tick_if.src tick
);
  logic [15:0] cyc_reg;
  logic [9:0] ms_reg;

  // Millisecond enable; the second is counted in ms so both stay aligned
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cyc_reg <= 16'h0000;
      ms_reg <= 10'h000;
      tick.ms_tick <= 1'b0;
      tick.sec_tick <= 1'b0;
    end else begin
      tick.ms_tick <= 1'b0;
      tick.sec_tick <= 1'b0;
      if (cyc_reg == 16'(MS_CYCLES - 1)) begin
        cyc_reg <= 16'h0000;
        tick.ms_tick <= 1'b1;
        if (ms_reg == 10'(SEC_MS - 1)) begin
          ms_reg <= 10'h000;
          tick.sec_tick <= 1'b1;
        end else begin
          ms_reg <= ms_reg + 10'h001;
        end
      end else begin
        cyc_reg <= cyc_reg + 16'h0001;
      end
    end
  end
endmodule : fsm_tick_gen

// file: hdl/fsm_monitor.sv
// Slave state machine, link status, status code and frame statistics
// What this block does
// RULE1 - Link status Initializing until connection opens
// RULE2 - PreOp or SafeOp command gives link code 6
// RULE3 - Op command gives link code 3
// RULE4 - Connection lost: Failing, then Faulted after timeout
// RULE5 - Report state codes 1,3,4,5; Init at start
// RULE6 - Master requests; device follows commanded state
// RULE7 - Process data watchdog expiry: SafeOp error 0x001B
// RULE8 - Bootstrap refused with 0x0013, Init with error
// RULE9 - Count good and bad frames per second
// RULE10 - Report operating mode codes 1,2,3
// RULE11 - Hold 16-bit status code; zero means OK
// RULE12 - Result is a state plus separate error flag
// RULE13 - Illegal transitions 0x0011, unknown 0x0012, stay errored
// RULE14 - Bad sync-manager config on transition: 0x0017
// RULE15 - Codes 0x0018-0x001A give SafeOp with error
// RULE16 - 0x001C SafeOp error; 0x001D-0x001F PreOp error
// RULE17 - Codes 0x0024-0x0029 leave PreOp with error
// RULE18 - DC config errors: PreOp or SafeOp by phase
// RULE19 - Codes 0x0020-0x0023 reported with error state
// RULE20 - Sync faults SafeOp error; 0x002A PreOp error
// RULE21 - Report watchdog time in milliseconds
// RULE22 - Report select mode, product code, revision
// RULE23 - Fault delay is watchdog plus timeout seconds
// RULE24 - Error latched until a valid change clears it
`timescale 1ns/10ps
module fsm_monitor #(
  parameter int unsigned MS_CYCLES = fsm_pkg::MS_CYC,
  parameter int unsigned SEC_MS = 1000
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic conn_open_i,
  input wire logic req_valid_i,
  input wire logic [3:0] req_state_i,
  input wire logic fault_valid_i,
  input wire logic [15:0] fault_code_i,
  input wire logic sm_cfg_ok_i,
  input wire logic pd_good_i,
  input wire logic pd_bad_i,
  input wire logic [15:0] wdog_ms_i,
  input wire logic [15:0] comm_timeout_s_i,
  input wire logic [15:0] station_alias_i,
  input wire logic [1:0] op_mode_i,
  input wire logic [1:0] description_file_select_i,
  input wire logic [31:0] product_code_i,
  input wire logic [15:0] revision_i,
  output logic [2:0] generic_link_status_o,
  output logic [2:0] slave_state_o,
  output logic error_flag_o,
  output logic [15:0] al_status_o,
  output logic [13:0] good_frames_o,
  output logic [3:0] bad_frames_o,
  output logic [1:0] op_mode_o,
  output logic [15:0] wdog_ms_o,
  output logic [15:0] station_alias_o,
  output logic [1:0] description_file_select_o,
  output logic [31:0] product_code_o,
  output logic [15:0] revision_o
);
  fsm_tick_if tick_bus ();
  fsm_pkg::fsm_state_t state_reg;
  fsm_pkg::fsm_state_t state_next;
  logic err_next;
  logic [15:0] code_next;
  logic take_next;
  logic conn_s1_reg;
  logic conn_s2_reg;
  logic conn_s3_reg;
  logic conn_reg;
  logic seen_conn_reg;
  logic lost_reg;
  logic [15:0] pd_ms_reg;
  logic [15:0] fail_ms_reg;
  logic [15:0] fail_s_reg;
  logic [13:0] good_cnt_reg;
  logic [3:0] bad_cnt_reg;

  fsm_tick_gen #(
    .MS_CYCLES(MS_CYCLES),
    .SEC_MS(SEC_MS)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick(tick_bus.src)
  );

  // Map internal state to the reported run code
  function automatic logic [2:0] run_code(input fsm_pkg::fsm_state_t s);
    unique case (s)
      fsm_pkg::ST_INIT: run_code = fsm_pkg::RUN_INIT;
      fsm_pkg::ST_PREOP: run_code = fsm_pkg::RUN_PREOP;
      fsm_pkg::ST_SAFEOP: run_code = fsm_pkg::RUN_SAFEOP;
      fsm_pkg::ST_OP: run_code = fsm_pkg::RUN_OP;
    endcase
  endfunction : run_code

  // Three-stage synchroniser; change counts when stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      conn_s1_reg <= 1'b0;
      conn_s2_reg <= 1'b0;
      conn_s3_reg <= 1'b0;
      conn_reg <= 1'b0;
    end else begin
      conn_s1_reg <= conn_open_i;
      conn_s2_reg <= conn_s1_reg;
      conn_s3_reg <= conn_s2_reg;
      if (conn_s2_reg == conn_s3_reg) begin
        conn_reg <= conn_s3_reg;
      end
    end
  end

  // Next state, error and code; faults win over requests in one cycle
  always_comb begin
    state_next = state_reg;
    err_next = error_flag_o;
    code_next = al_status_o;
    take_next = 1'b0;
    if (!conn_reg) begin
      state_next = fsm_pkg::ST_INIT; // RULE5
      take_next = 1'b1;
    end else if (state_reg == fsm_pkg::ST_OP && tick_bus.ms_tick &&
                 wdog_ms_i != 16'h0000 && pd_ms_reg >= wdog_ms_i) begin
      state_next = fsm_pkg::ST_SAFEOP; // RULE7
      err_next = 1'b1; // RULE12
      code_next = fsm_pkg::AL_SM_WDOG; // RULE7
      take_next = 1'b1;
    end else if (fault_valid_i && fault_code_i != fsm_pkg::AL_OK) begin
      err_next = 1'b1; // RULE12
      code_next = fault_code_i; // RULE11 RULE19
      take_next = 1'b1;
      unique case (fault_code_i)
        16'h0018, 16'h0019, 16'h001a, 16'h001b, 16'h001c, 16'h002b,
        16'h002c, 16'h002d, 16'h0032, 16'h0033: begin
          if (state_reg != fsm_pkg::ST_INIT &&
              state_reg != fsm_pkg::ST_PREOP) begin
            state_next = fsm_pkg::ST_SAFEOP; // RULE15 RULE16 RULE20
          end
        end
        16'h001d, 16'h001e, 16'h001f, 16'h002a, 16'h0024, 16'h0025,
        16'h0026, 16'h0027, 16'h0028, 16'h0029: begin
          if (state_reg != fsm_pkg::ST_INIT) begin
            state_next = fsm_pkg::ST_PREOP; // RULE16 RULE17 RULE20
          end
        end
        16'h0030, 16'h0031: begin
          // Found entering SafeOp we sit in PreOp; later phases drop
          if (state_reg == fsm_pkg::ST_OP) begin
            state_next = fsm_pkg::ST_SAFEOP; // RULE18
          end
        end
        16'h0021: state_next = fsm_pkg::ST_INIT; // RULE19
        16'h0022, 16'h0023: begin
          if (state_reg == fsm_pkg::ST_OP) begin
            state_next = fsm_pkg::ST_SAFEOP; // RULE19
          end
        end
        default: state_next = state_reg; // Other codes: current + error
      endcase
    end else if (req_valid_i) begin
      take_next = 1'b1;
      unique case (req_state_i)
        fsm_pkg::REQ_BOOT: begin
          err_next = 1'b1; // RULE8
          if (state_reg == fsm_pkg::ST_INIT) begin
            code_next = fsm_pkg::AL_NO_BOOT; // RULE8
          end else begin
            code_next = fsm_pkg::AL_BAD_CHANGE; // RULE13
          end
        end
        fsm_pkg::REQ_INIT, fsm_pkg::REQ_PREOP: begin
          state_next = (req_state_i == fsm_pkg::REQ_INIT) ?
                       fsm_pkg::ST_INIT : fsm_pkg::ST_PREOP; // RULE6
          err_next = 1'b0; // RULE24
          code_next = fsm_pkg::AL_OK; // RULE24
        end
        fsm_pkg::REQ_SAFEOP: begin
          if (state_reg == fsm_pkg::ST_INIT) begin
            err_next = 1'b1;
            code_next = fsm_pkg::AL_BAD_CHANGE; // RULE13
          end else if (state_reg == fsm_pkg::ST_PREOP && !sm_cfg_ok_i) begin
            err_next = 1'b1;
            code_next = fsm_pkg::AL_SM_CFG; // RULE14
          end else begin
            state_next = fsm_pkg::ST_SAFEOP; // RULE6
            err_next = 1'b0; // RULE24
            code_next = fsm_pkg::AL_OK;
          end
        end
        fsm_pkg::REQ_OP: begin
          if (state_reg == fsm_pkg::ST_INIT ||
              state_reg == fsm_pkg::ST_PREOP) begin
            err_next = 1'b1;
            code_next = fsm_pkg::AL_BAD_CHANGE; // RULE13
          end else if (state_reg == fsm_pkg::ST_SAFEOP && !sm_cfg_ok_i) begin
            err_next = 1'b1;
            code_next = fsm_pkg::AL_SM_CFG; // RULE14
          end else begin
            state_next = fsm_pkg::ST_OP; // RULE6
            err_next = 1'b0; // RULE24
            code_next = fsm_pkg::AL_OK;
          end
        end
        default: begin
          err_next = 1'b1;
          code_next = fsm_pkg::AL_UNKNOWN; // RULE13
        end
      endcase
    end
  end

  // Slave state, error flag and status code latch
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= fsm_pkg::ST_INIT; // RULE5
      error_flag_o <= 1'b0;
      al_status_o <= fsm_pkg::AL_OK;
      slave_state_o <= fsm_pkg::RUN_INIT;
    end else begin
      if (take_next && conn_reg) begin
        error_flag_o <= err_next; // RULE24
        al_status_o <= code_next; // RULE11
      end
      state_reg <= state_next;
      slave_state_o <= run_code(state_next); // RULE5
    end
  end

  // Process-data age in ms; restarts on every good frame
  always_ff @(posedge core_clk_i) begin
    if (rst_i || pd_good_i || state_reg != fsm_pkg::ST_OP) begin
      pd_ms_reg <= 16'h0000;
    end else if (tick_bus.ms_tick && pd_ms_reg != 16'hffff) begin
      pd_ms_reg <= pd_ms_reg + 16'h0001;
    end
  end

  // Connection history: failing only after a connection once existed
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      seen_conn_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else if (conn_reg) begin
      seen_conn_reg <= 1'b1;
      lost_reg <= 1'b0;
    end else if (seen_conn_reg) begin
      lost_reg <= 1'b1;
    end
  end

  // Failing timer: watchdog ms first, then timeout seconds
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !lost_reg) begin
      fail_ms_reg <= 16'h0000;
      fail_s_reg <= 16'h0000;
    end else begin
      if (tick_bus.ms_tick && fail_ms_reg < wdog_ms_i) begin
        fail_ms_reg <= fail_ms_reg + 16'h0001; // RULE23
      end
      if (tick_bus.sec_tick && fail_ms_reg >= wdog_ms_i &&
          fail_s_reg < comm_timeout_s_i) begin
        fail_s_reg <= fail_s_reg + 16'h0001; // RULE23
      end
    end
  end

  // Generic link status
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      generic_link_status_o <= fsm_pkg::LINK_INIT; // RULE1
    end else if (!seen_conn_reg && !conn_reg) begin
      generic_link_status_o <= fsm_pkg::LINK_INIT; // RULE1
    end else if (lost_reg) begin
      if (fail_ms_reg >= wdog_ms_i && fail_s_reg >= comm_timeout_s_i) begin
        generic_link_status_o <= fsm_pkg::LINK_FAULTED; // RULE4
      end else begin
        generic_link_status_o <= fsm_pkg::LINK_FAILING; // RULE4
      end
    end else if (state_next == fsm_pkg::ST_OP) begin
      generic_link_status_o <= fsm_pkg::LINK_OP; // RULE3
    end else if (state_next != fsm_pkg::ST_INIT) begin
      generic_link_status_o <= fsm_pkg::LINK_PREOP; // RULE2
    end
  end

  // Per-second frame counts; saturate rather than wrap
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      good_cnt_reg <= 14'h0000;
      bad_cnt_reg <= 4'h0;
      good_frames_o <= 14'h0000;
      bad_frames_o <= 4'h0;
    end else if (tick_bus.sec_tick) begin
      good_frames_o <= good_cnt_reg; // RULE9
      bad_frames_o <= bad_cnt_reg; // RULE9
      good_cnt_reg <= {13'h0000, pd_good_i};
      bad_cnt_reg <= {3'h0, pd_bad_i};
    end else begin
      if (pd_good_i && good_cnt_reg != fsm_pkg::GOOD_MAX) begin
        good_cnt_reg <= good_cnt_reg + 14'h0001;
      end
      if (pd_bad_i && bad_cnt_reg != fsm_pkg::BAD_MAX) begin
        bad_cnt_reg <= bad_cnt_reg + 4'h1;
      end
    end
  end

  // Monitor values registered so every output comes from a flip-flop
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      op_mode_o <= fsm_pkg::MODE_NONE;
      wdog_ms_o <= 16'h0000;
      station_alias_o <= 16'h0000;
      description_file_select_o <= fsm_pkg::DSEL_OFF;
      product_code_o <= 32'h00000000;
      revision_o <= 16'h0000;
    end else begin
      // Code 0 is not a legal mode; shown as undefined
      op_mode_o <= (op_mode_i == 2'h0) ? fsm_pkg::MODE_NONE
                   : op_mode_i; // RULE10
      wdog_ms_o <= wdog_ms_i; // RULE21
      station_alias_o <= station_alias_i;
      description_file_select_o <= (description_file_select_i == 2'h0) ?
                                   fsm_pkg::DSEL_OFF
                                   : description_file_select_i; // RULE22
      product_code_o <= product_code_i; // RULE22
      revision_o <= revision_i; // RULE22
    end
  end

  // Boot request from Init refuses with its own code and error
  a_boot_refused: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conn_reg && !fault_valid_i && req_valid_i && req_state_i == 4'h3 &&
    state_reg == fsm_pkg::ST_INIT |=> al_status_o == 16'h0013 &&
    error_flag_o && slave_state_o == 3'h1) // RULE8
    else $error("boot request not refused");

  a_illegal_op: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conn_reg && !fault_valid_i && req_valid_i && req_state_i == 4'h8 &&
    state_reg == fsm_pkg::ST_PREOP && !(tick_bus.ms_tick &&
    state_reg == fsm_pkg::ST_OP) |=> al_status_o == 16'h0011 &&
    slave_state_o == 3'h3) // RULE13
    else $error("preop to op not rejected");

  // Without a synced connection the reported state must fall to Init
  a_state_code: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !conn_reg |=> slave_state_o == 3'h1) // RULE5
    else $error("slave state not init without connection");

  a_wdog_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conn_reg && state_reg == fsm_pkg::ST_OP && tick_bus.ms_tick &&
    wdog_ms_i != 16'h0000 && pd_ms_reg >= wdog_ms_i
    |=> slave_state_o == 3'h4 && al_status_o == 16'h001b) // RULE7
    else $error("watchdog did not drop to safeop");

  // Link status follows the state being entered, so a fault that drops
  // Op in this cycle must not be held to the operational code
  a_link_op: assert property (@(posedge core_clk_i) disable iff (rst_i)
    conn_reg && !lost_reg && state_next == fsm_pkg::ST_OP
    |=> generic_link_status_o == 3'h3) // RULE3
    else $error("link status not operational");

  a_link_init: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !seen_conn_reg && !$past(seen_conn_reg) && !$past(conn_reg)
    |-> generic_link_status_o == 3'h1) // RULE1
    else $error("link status left init early");

  a_error_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    error_flag_o && !req_valid_i && conn_reg
    |=> error_flag_o) // RULE24
    else $error("error flag cleared without request");

  a_sec_counts: assert property (@(posedge core_clk_i) disable iff (rst_i)
    tick_bus.sec_tick |=> good_frames_o == $past(good_cnt_reg)) // RULE9
    else $error("good frame count not published");
endmodule : fsm_monitor

// file: sim/fsm_master_model.sv
// Behavioural fieldbus master: connection, state requests, faults, frames
`timescale 1ns/10ps
module fsm_master_model (
  input wire logic core_clk_i,
  output logic conn_open_o,
  output logic req_valid_o,
  output logic [3:0] req_state_o,
  output logic fault_valid_o,
  output logic [15:0] fault_code_o,
  output logic pd_good_o,
  output logic pd_bad_o
);
  logic stream_on;
  logic [1:0] phase_reg;

  // Idle values; qualifiers start as a pattern, never a copy of real data
  initial begin
    conn_open_o = 1'h0;
    req_valid_o = 1'h0;
    req_state_o = 4'hf;
    fault_valid_o = 1'h0;
    fault_code_o = 16'hffff;
    pd_good_o = 1'h0;
    pd_bad_o = 1'h0;
    stream_on = 1'h0;
    phase_reg = 2'h0;
  end

  // Frames while streaming: good each cycle, failed every fourth cycle
  always @(posedge core_clk_i) begin
    phase_reg <= phase_reg + 2'h1;
    pd_good_o <= #1 stream_on;
    pd_bad_o <= #1 stream_on && (phase_reg == 2'h0);
  end

  // One-cycle strobe; afterwards the qualifiers are inverted so a stale
  // value can never pass for a fresh one
  task automatic send(input logic is_fault, input logic [15:0] val);
    @(posedge core_clk_i);
    #1;
    if (is_fault) begin
      fault_valid_o = 1'h1;
      fault_code_o = val;
    end else begin
      req_valid_o = 1'h1;
      req_state_o = val[3:0];
    end
    @(posedge core_clk_i);
    #1;
    req_valid_o = 1'h0;
    fault_valid_o = 1'h0;
    req_state_o = ~req_state_o;
    fault_code_o = ~fault_code_o;
  endtask : send
endmodule : fsm_master_model

// file: sim/testbench.sv
// Self-checking bench for the slave state monitor
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic f;
    logic [15:0] v;
    logic cfg;
    logic [2:0] st;
    logic er;
    logic [15:0] cd;
    logic [2:0] lk;
  } fsm_row_t;

  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic conn_open, req_valid, fault_valid, pd_good, pd_bad;
  logic [3:0] req_state;
  logic [15:0] fault_code;
  logic sm_cfg_ok_i = 1'h1;
  logic [15:0] wdog_ms_i = 16'h0000;
  logic [15:0] comm_timeout_s_i = 16'h0001;
  logic [15:0] station_alias_i = 16'h0000;
  logic [1:0] op_mode_i = 2'h0;
  logic [1:0] description_file_select_i = 2'h0;
  logic [31:0] product_code_i = 32'h00000000;
  logic [15:0] revision_i = 16'h0000;
  logic [2:0] generic_link_status_o, slave_state_o;
  logic error_flag_o;
  logic [15:0] al_status_o, wdog_ms_o, station_alias_o, revision_o;
  logic [13:0] good_frames_o;
  logic [3:0] bad_frames_o;
  logic [1:0] op_mode_o, description_file_select_o;
  logic [31:0] product_code_o;
  int n_fail = 0;
  int samples_checked = 0;
  fsm_row_t rows [0:28];

  // 4 cycles a millisecond, 5 ms a second keeps timeouts short
  fsm_monitor #(.MS_CYCLES(4), .SEC_MS(5)) fsm_monitor_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .conn_open_i(conn_open),
    .req_valid_i(req_valid), .req_state_i(req_state),
    .fault_valid_i(fault_valid), .fault_code_i(fault_code),
    .sm_cfg_ok_i(sm_cfg_ok_i), .pd_good_i(pd_good), .pd_bad_i(pd_bad),
    .wdog_ms_i(wdog_ms_i), .comm_timeout_s_i(comm_timeout_s_i),
    .station_alias_i(station_alias_i), .op_mode_i(op_mode_i),
    .description_file_select_i(description_file_select_i),
    .product_code_i(product_code_i), .revision_i(revision_i),
    .generic_link_status_o(generic_link_status_o),
    .slave_state_o(slave_state_o), .error_flag_o(error_flag_o),
    .al_status_o(al_status_o), .good_frames_o(good_frames_o),
    .bad_frames_o(bad_frames_o), .op_mode_o(op_mode_o),
    .wdog_ms_o(wdog_ms_o), .station_alias_o(station_alias_o),
    .description_file_select_o(description_file_select_o),
    .product_code_o(product_code_o), .revision_o(revision_o));

  fsm_master_model master_inst (
    .core_clk_i(core_clk_i), .conn_open_o(conn_open),
    .req_valid_o(req_valid), .req_state_o(req_state),
    .fault_valid_o(fault_valid), .fault_code_o(fault_code),
    .pd_good_o(pd_good), .pd_bad_o(pd_bad));

  // 25 MHz core clock
  always #20 core_clk_i = ~core_clk_i;

  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick

  // Bounded wait on link status (sel 0) or slave state (sel 1)
  task automatic wait_out(input int sel, input logic [2:0] val);
    int i;
    for (i = 0; i < 200; i++) begin
      if ((sel == 0 ? generic_link_status_o : slave_state_o) === val) break;
      tick(1);
    end
    if (i == 200) begin
      n_fail++;
      close_out();
    end
  endtask : wait_out

  task automatic check_reset;
    check("link", generic_link_status_o, 3'h1);
    check("state", slave_state_o, 3'h1);
    check("error", error_flag_o, 1'h0);
    check("status", al_status_o, 16'h0000);
  endtask : check_reset

  initial begin
    // Request or fault, value, sm config ok, then state, error, code, link
    rows = '{
      '{1'h0, 16'h0002, 1'h1, 3'h3, 1'h0, 16'h0000, 3'h6},
      '{1'h0, 16'h0008, 1'h1, 3'h3, 1'h1, 16'h0011, 3'h0},
      '{1'h0, 16'h0003, 1'h1, 3'h3, 1'h1, 16'h0011, 3'h0},
      '{1'h0, 16'h0005, 1'h1, 3'h3, 1'h1, 16'h0012, 3'h0},
      '{1'h0, 16'h0004, 1'h0, 3'h3, 1'h1, 16'h0017, 3'h0},
      '{1'h0, 16'h0004, 1'h1, 3'h4, 1'h0, 16'h0000, 3'h6},
      '{1'h0, 16'h0008, 1'h1, 3'h5, 1'h0, 16'h0000, 3'h3},
      '{1'h1, 16'h0018, 1'h1, 3'h4, 1'h1, 16'h0018, 3'h0},
      '{1'h0, 16'h0008, 1'h1, 3'h5, 1'h0, 16'h0000, 3'h3},
      '{1'h1, 16'h001a, 1'h1, 3'h4, 1'h1, 16'h001a, 3'h0},
      '{1'h0, 16'h0008, 1'h1, 3'h5, 1'h0, 16'h0000, 3'h3},
      '{1'h1, 16'h0031, 1'h1, 3'h4, 1'h1, 16'h0031, 3'h0},
      '{1'h1, 16'h001c, 1'h1, 3'h4, 1'h1, 16'h001c, 3'h0},
      '{1'h1, 16'h0022, 1'h1, 3'h4, 1'h1, 16'h0022, 3'h0},
      '{1'h1, 16'h0000, 1'h1, 3'h4, 1'h1, 16'h0022, 3'h0},
      '{1'h0, 16'h0009, 1'h1, 3'h4, 1'h1, 16'h0012, 3'h0},
      '{1'h1, 16'h001d, 1'h1, 3'h3, 1'h1, 16'h001d, 3'h0},
      '{1'h0, 16'h0004, 1'h1, 3'h4, 1'h0, 16'h0000, 3'h6},
      '{1'h1, 16'h002a, 1'h1, 3'h3, 1'h1, 16'h002a, 3'h0},
      '{1'h0, 16'h0001, 1'h1, 3'h1, 1'h0, 16'h0000, 3'h0},
      '{1'h0, 16'h0003, 1'h1, 3'h1, 1'h1, 16'h0013, 3'h0},
      '{1'h0, 16'h0004, 1'h1, 3'h1, 1'h1, 16'h0011, 3'h0},
      '{1'h0, 16'h0008, 1'h1, 3'h1, 1'h1, 16'h0011, 3'h0},
      '{1'h0, 16'h0002, 1'h1, 3'h3, 1'h0, 16'h0000, 3'h6},
      '{1'h1, 16'h0027, 1'h1, 3'h3, 1'h1, 16'h0027, 3'h0},
      '{1'h1, 16'h0030, 1'h1, 3'h3, 1'h1, 16'h0030, 3'h0},
      '{1'h0, 16'h0004, 1'h1, 3'h4, 1'h0, 16'h0000, 3'h6},
      '{1'h0, 16'h0008, 1'h1, 3'h5, 1'h0, 16'h0000, 3'h3},
      '{1'h1, 16'h002b, 1'h1, 3'h4, 1'h1, 16'h002b, 3'h0}};
    tick(2);
    rst_i = 1'h0;
    tick(2);
    check_reset();
    check("op_mode", op_mode_o, 2'h1);
    // Requests before the connection opens are not taken
    master_inst.send(1'h0, 16'h0002);
    check_reset();
    master_inst.conn_open_o = 1'h1;
    tick(6);
    // Monitor values follow their sources, every mode code once
    for (int k = 1; k < 4; k++) begin
      op_mode_i = k[1:0];
      description_file_select_i = k[1:0];
      wdog_ms_i = 16'hfff0 + k[15:0];
      station_alias_i = 16'h1230 + k[15:0];
      product_code_i = 32'ha5c30000 + k;
      revision_i = 16'h0100 + k[15:0];
      tick(3);
      check("op_mode", op_mode_o, k[1:0]);
      check("dsel", description_file_select_o, k[1:0]);
      check("wdog", wdog_ms_o, 16'hfff0 + k[15:0]);
      check("alias", station_alias_o, 16'h1230 + k[15:0]);
      check("product", product_code_o, 32'ha5c30000 + k);
      check("revision", revision_o, 16'h0100 + k[15:0]);
    end
    wdog_ms_i = 16'h0000;
    // Ordinary transitions and faults
    for (int i = 0; i < 29; i++) begin
      sm_cfg_ok_i = rows[i].cfg;
      master_inst.send(rows[i].f, rows[i].v);
      check("state", slave_state_o, rows[i].st);
      check("error", error_flag_o, rows[i].er);
      check("status", al_status_o, rows[i].cd);
      if (rows[i].lk !== 3'h0)
        check("link", generic_link_status_o, rows[i].lk);
    end
    // Watchdog kept alive by frames, then starved
    wdog_ms_i = 16'h0002;
    master_inst.stream_on = 1'h1;
    master_inst.send(1'h0, 16'h0008);
    tick(45);
    check("state", slave_state_o, 3'h5);
    check("good", good_frames_o, 14'h0014);
    check("bad", bad_frames_o, 4'h5);
    master_inst.stream_on = 1'h0;
    wait_out(1, 3'h4);
    check("status", al_status_o, 16'h001b);
    check("error", error_flag_o, 1'h1);
    // Connection loss: failing first, faulted after watchdog plus timeout
    master_inst.conn_open_o = 1'h0;
    wait_out(0, 3'h5);
    check("state", slave_state_o, 3'h1);
    tick(6);
    check("link", generic_link_status_o, 3'h5);
    wait_out(0, 3'h4);
    check("link", generic_link_status_o, 3'h4);
    // Second reset in mid-run
    rst_i = 1'h1;
    tick(2);
    rst_i = 1'h0;
    tick(1);
    check_reset();
    check("good", good_frames_o, 14'h0000);
    close_out();
  end
endmodule : testbench
